// file: pmsc_pkg.sv
// Purpose: Constants and types shared by the MAC-side control register bank.
// Assumes: 16-bit registers reached by a plain strobe port with one-cycle read latency.
// Notes: Offsets are register indices on the management port.
//
// Summary of operation
// - Bypass permission bit resets to 1; written value applies only after soft reset.
// - Bypass outcome reads 1 when link came up by bypass timer expiry.
// - Bypass outcome reads 0 after normal negotiation; cleared by both resets.
// - Whenever bypass outcome reads 1, fiber negotiation-complete bit 11 reads 0.
// - Transmitter disable bit gates fiber transmitter; resets 0, kept over soft reset.
// - Three-bit amplitude code, default 2, kept over soft reset.
// - Odd-nibble preamble bit: 0 pads, 1 passes; default 1.
// - Receive-clock power bit: 1 keeps clock running, 0 allows stopping; default 1.
// - Power control applies on power-down bits or energy detect state.
// - Receive-clock power change takes effect only at a software reset.
// - Interrupt enables for FIFO error bit 7, idle inserted 3, idle deleted 2.
// - FIFO over/underflow status latches high; cleared by both resets.
package pmsc_pkg;
	localparam int          REG_W        = 16;
	localparam int          ADDR_W       = 5;
	localparam logic [4:0]  OFS_SERCTL   = 5'h1a;
	localparam logic [4:0]  OFS_MACCTL   = 5'h10;
	localparam logic [4:0]  OFS_INTEN    = 5'h12;
	localparam logic [4:0]  OFS_STATUS   = 5'h13;
	localparam logic [4:0]  OFS_FIBST    = 5'h11;
	// Serial control fields.
	localparam int          B_BYPEN      = 6;
	localparam int          B_BYPST      = 5;
	localparam int          B_SRES4      = 4;
	localparam int          B_TXDIS      = 3;
	localparam int          B_AMPHI      = 2;
	// Only the outcome bit is read-only; the permission bit is stored as a pending value.
	localparam logic [15:0] SERCTL_WMASK = 16'hffdf;
	localparam logic [15:0] SERCTL_RST   = 16'h0042;
	// MAC control fields.
	localparam int          B_ODDPASS    = 6;
	localparam int          B_RXCKON     = 3;
	localparam logic [15:0] MACCTL_RST   = 16'h4448;
	// Interrupt enable and status fields.
	localparam int          B_FIFOERR    = 7;
	localparam int          B_IDLEINS    = 3;
	localparam int          B_IDLEDEL    = 2;
	localparam logic [15:0] INTEN_RST    = 16'h0000;
	localparam logic [15:0] EVENT_MASK   = 16'h008c;
	localparam int          B_FIBANC     = 11;
	localparam logic [15:0] ZERO16       = 16'h0000;
	typedef enum logic [1:0] {LINK_DOWN, LINK_BYPASS, LINK_NEGOTIATED} pmsc_link_t;
endpackage : pmsc_pkg

// file: pmsc_ev_if.sv
// Purpose: Carries latched event status between the bank and its status latch.
// Assumes: One clock domain.
// Notes: Clear-on-read strobe comes from the bank.
`timescale 1ns/100ps
`default_nettype none
interface pmsc_ev_if;
	logic [15:0] rawEvt;
	logic        rdClr;
	logic [15:0] latched;
	modport bank  (output rawEvt, output rdClr, input latched);
	modport latch (input rawEvt, input rdClr, output latched);
endinterface : pmsc_ev_if
`default_nettype wire

// file: pmsc_evt_latch.sv
// Purpose: Latched-high event status bits with clear on read.
// Assumes: Events are single-cycle or level conditions.
// Notes: A set in the read cycle wins, so no event is lost.
`timescale 1ns/100ps
`default_nettype none
module pmsc_evt_latch
	import pmsc_pkg::*;
(
	// Clock and reset
	input  wire logic mclk,
	input  wire logic rst_n,
	input  wire logic swRst,
	// Event carrier
	pmsc_ev_if.latch  ev
);
	genvar i;
	generate
		for (i = 0; i < REG_W; i++) begin : g_bit
			if (EVENT_MASK[i]) begin : g_ev
				logic bit_q;
				always_ff @(posedge mclk or negedge rst_n) begin
					if (!rst_n)
						bit_q <= 1'b0;
					else if (ev.rawEvt[i])
						bit_q <= 1'b1;
					else if (ev.rdClr || swRst)
						bit_q <= 1'b0;
				end
				assign ev.latched[i] = bit_q;
			end else begin : g_res
				assign ev.latched[i] = 1'b0;
			end
		end
	endgenerate
endmodule : pmsc_evt_latch
`default_nettype wire

// file: pmsc_bypass_track.sv
// Purpose: Records how the serial link last came up.
// Assumes: Up indications are single-cycle pulses from the link logic.
// Notes: Bypass is only honoured while the applied permission bit is set.
`timescale 1ns/100ps
`default_nettype none
module pmsc_bypass_track
	import pmsc_pkg::*;
(
	// Clock and reset
	input  wire logic mclk,
	input  wire logic rst_n,
	input  wire logic swRst,
	// Link events
	input  wire logic bypassAllowed,
	input  wire logic upByBypass,
	input  wire logic upByNegotiation,
	input  wire logic linkDown,
	// Outcome
	output logic      bypassOutcome
);
	pmsc_link_t state_q;
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			state_q <= LINK_DOWN;
		else if (swRst || linkDown)
			state_q <= LINK_DOWN;
		else
			case (state_q)
				LINK_DOWN: begin
					if (upByBypass && bypassAllowed)
						state_q <= LINK_BYPASS;
					else if (upByNegotiation)
						state_q <= LINK_NEGOTIATED;
				end
				LINK_BYPASS:     state_q <= LINK_BYPASS;
				LINK_NEGOTIATED: state_q <= LINK_NEGOTIATED;
				default:         state_q <= LINK_DOWN;
			endcase
	end
	assign bypassOutcome = (state_q == LINK_BYPASS);
endmodule : pmsc_bypass_track
`default_nettype wire

// file: pmsc_regs.sv
// Purpose: MAC-side and serial-link control and status register bank.
// Assumes: Management port strobes are synchronous, one cycle, never both at once.
// Notes: Fields marked disruptive take effect only at a software reset.
`timescale 1ns/100ps
`default_nettype none
module pmsc_regs
	import pmsc_pkg::*;
(
	// Clock and reset
	input  wire logic              mclk,
	input  wire logic              rst_n,
	input  wire logic              swRst,
	// Management port
	input  wire logic [ADDR_W-1:0] regAddr,
	input  wire logic [REG_W-1:0]  regWdata,
	input  wire logic              regWr,
	input  wire logic              regRd,
	output logic      [REG_W-1:0]  regRdata,
	// Link status inputs
	input  wire logic              upByBypass,
	input  wire logic              upByNegotiation,
	input  wire logic              serLinkDown,
	input  wire logic              fibNegComplete,
	// Copper FIFO events
	input  wire logic              fifoErr,
	input  wire logic              idleInserted,
	input  wire logic              idleDeleted,
	// Power-down sources
	input  wire logic              pwrDownMain,
	input  wire logic              pwrDownCopper,
	input  wire logic              energyDetect,
	// Controls
	output logic                   bypassEnable,
	output logic                   fiberTxDisable,
	output logic      [2:0]        serAmplitude,
	output logic                   passOddPreamble,
	output logic                   rxClkRun,
	output logic                   irq
);
	logic [REG_W-1:0] serCtl_q;
	logic [REG_W-1:0] macCtl_q;
	logic [REG_W-1:0] intEn_q;
	logic             bypEnApplied_q;
	logic             oddPassApplied_q;
	logic             rxCkApplied_q;
	logic [REG_W-1:0] rdata_q;
	logic             bypassOutcome;
	logic             fibNegShown;

	pmsc_ev_if ev ();

	// Serial control: disruptive bits hold a pending value until soft reset.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			serCtl_q <= SERCTL_RST;
		else if (regWr && regAddr == OFS_SERCTL)
			serCtl_q <= regWdata & SERCTL_WMASK;
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			bypEnApplied_q <= SERCTL_RST[B_BYPEN];
		else if (swRst)
			bypEnApplied_q <= serCtl_q[B_BYPEN];
	end

	// MAC control: reserved bits are stored as written; software keeps them at reset values.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			macCtl_q <= MACCTL_RST;
		else if (regWr && regAddr == OFS_MACCTL)
			macCtl_q <= regWdata;
	end

	// Applying at soft reset avoids glitching the receive clock mid-frame.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			oddPassApplied_q <= MACCTL_RST[B_ODDPASS];
			rxCkApplied_q    <= MACCTL_RST[B_RXCKON];
		end else if (swRst) begin
			oddPassApplied_q <= macCtl_q[B_ODDPASS];
			rxCkApplied_q    <= macCtl_q[B_RXCKON];
		end
	end

	// Interrupt enables: retained over soft reset.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			intEn_q <= INTEN_RST;
		else if (regWr && regAddr == OFS_INTEN)
			intEn_q <= regWdata & EVENT_MASK;
	end

	pmsc_bypass_track u_byp (
		.mclk            (mclk),
		.rst_n           (rst_n),
		.swRst           (swRst),
		.bypassAllowed   (bypEnApplied_q),
		.upByBypass      (upByBypass),
		.upByNegotiation (upByNegotiation),
		.linkDown        (serLinkDown),
		.bypassOutcome   (bypassOutcome)
	);

	always_comb begin
		ev.rawEvt             = ZERO16;
		ev.rawEvt[B_FIFOERR]  = fifoErr;
		ev.rawEvt[B_IDLEINS]  = idleInserted;
		ev.rawEvt[B_IDLEDEL]  = idleDeleted;
	end
	assign ev.rdClr = regRd && (regAddr == OFS_STATUS);

	pmsc_evt_latch u_lat (
		.mclk  (mclk),
		.rst_n (rst_n),
		.swRst (swRst),
		.ev    (ev)
	);

	// Negotiation-complete indication is masked while the link is up by bypass.
	assign fibNegShown = fibNegComplete && !bypassOutcome;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			rdata_q <= ZERO16;
		else if (regRd) begin
			case (regAddr)
				OFS_SERCTL: begin
					rdata_q          <= serCtl_q;
					rdata_q[B_BYPST] <= bypassOutcome;
				end
				OFS_MACCTL: rdata_q <= macCtl_q;
				OFS_INTEN:  rdata_q <= intEn_q;
				OFS_STATUS: rdata_q <= ev.latched;
				OFS_FIBST: begin
					rdata_q           <= ZERO16;
					rdata_q[B_FIBANC] <= fibNegShown;
				end
				default:    rdata_q <= ZERO16;
			endcase
		end else
			rdata_q <= ZERO16;
	end
	assign regRdata = rdata_q;

	assign bypassEnable    = bypEnApplied_q;
	assign fiberTxDisable  = serCtl_q[B_TXDIS];
	assign serAmplitude    = serCtl_q[B_AMPHI:0];
	assign passOddPreamble = oddPassApplied_q;
	// The clock may stop only in a power-down or energy detect state.
	assign rxClkRun = rxCkApplied_q || !(pwrDownMain || pwrDownCopper || energyDetect);
	assign irq      = |(ev.latched & intEn_q);
endmodule : pmsc_regs
`default_nettype wire

// file: pmsc_regs_monitor.sv
// Purpose: Port-level assertions for the MAC-side register bank.
// Assumes: One clock, asynchronous active-low reset.
// Notes: Pending fields are only seen through swRst, so holds are checked there.
`timescale 1ns/100ps
`default_nettype none
module pmsc_regs_monitor
	import pmsc_pkg::*;
(
	// Clock and reset
	input wire logic              mclk,
	input wire logic              rst_n,
	input wire logic              swRst,
	// Management port
	input wire logic [ADDR_W-1:0] regAddr,
	input wire logic [REG_W-1:0]  regWdata,
	input wire logic              regWr,
	input wire logic              regRd,
	input wire logic [REG_W-1:0]  regRdata,
	// Link and FIFO events
	input wire logic              upByBypass,
	input wire logic              upByNegotiation,
	input wire logic              serLinkDown,
	input wire logic              fibNegComplete,
	input wire logic              fifoErr,
	input wire logic              idleInserted,
	input wire logic              idleDeleted,
	// Power-down sources
	input wire logic              pwrDownMain,
	input wire logic              pwrDownCopper,
	input wire logic              energyDetect,
	// Controls
	input wire logic              bypassEnable,
	input wire logic              fiberTxDisable,
	input wire logic [2:0]        serAmplitude,
	input wire logic              passOddPreamble,
	input wire logic              rxClkRun,
	input wire logic              irq
);
	logic anyEvt;
	assign anyEvt = fifoErr | idleInserted | idleDeleted;
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	a_bypass_hold: assert property (!swRst |=> $stable(bypassEnable))
		else $error("bypassEnable changed without software reset");
	a_odd_hold: assert property (!swRst |=> $stable(passOddPreamble))
		else $error("passOddPreamble changed without software reset");
	a_txdis_write: assert property (regWr && regAddr == OFS_SERCTL |=> fiberTxDisable == $past(regWdata[B_TXDIS]))
		else $error("fiberTxDisable does not follow the write");
	a_amp_write: assert property (regWr && regAddr == OFS_SERCTL |=> serAmplitude == $past(regWdata[2:0]))
		else $error("serAmplitude does not follow the write");
	a_rxclk_src: assert property (!rxClkRun |-> pwrDownMain || pwrDownCopper || energyDetect)
		else $error("receive clock stopped without a power-down source");
	a_irq_cause: assert property ($rose(irq) |-> $past(anyEvt) || $past(regWr && regAddr == OFS_INTEN))
		else $error("irq rose without event or enable write");
	a_read_clear: assert property (regRd && regAddr == OFS_STATUS && !anyEvt |=> !irq)
		else $error("irq held after status read");
	a_status_mask: assert property (regRd && regAddr == OFS_STATUS |=> (regRdata & ~EVENT_MASK) == ZERO16)
		else $error("status read shows reserved bits");
	c_irq: cover property ($rose(irq));
	c_bypass: cover property (upByBypass && bypassEnable);
	c_swrst: cover property (swRst);
endmodule // pmsc_regs_monitor
bind pmsc_regs pmsc_regs_monitor pmsc_regs_monitor_i (
	.mclk            (mclk),
	.rst_n           (rst_n),
	.swRst           (swRst),
	.regAddr         (regAddr),
	.regWdata        (regWdata),
	.regWr           (regWr),
	.regRd           (regRd),
	.regRdata        (regRdata),
	.upByBypass      (upByBypass),
	.upByNegotiation (upByNegotiation),
	.serLinkDown     (serLinkDown),
	.fibNegComplete  (fibNegComplete),
	.fifoErr         (fifoErr),
	.idleInserted    (idleInserted),
	.idleDeleted     (idleDeleted),
	.pwrDownMain     (pwrDownMain),
	.pwrDownCopper   (pwrDownCopper),
	.energyDetect    (energyDetect),
	.bypassEnable    (bypassEnable),
	.fiberTxDisable  (fiberTxDisable),
	.serAmplitude    (serAmplitude),
	.passOddPreamble (passOddPreamble),
	.rxClkRun        (rxClkRun),
	.irq             (irq)
);
`default_nettype wire

// file: pmsc_link_model.sv
// Purpose: Far-side stand-in raising link and copper FIFO event pulses.
// Assumes: One clock; the bench picks the event.
// Notes: Each request with sel below 6 gives one single-cycle pulse, never a stuck level; sel 6 or 7 gives none.
`timescale 1ns/100ps
`default_nettype none
module pmsc_link_model
(
	// Clock and request
	input  wire logic       mclk,
	input  wire logic       fire,
	input  wire logic [2:0] sel,
	// Event pulses
	output logic      [5:0] evt
);
	always_ff @(posedge mclk) begin
		evt <= fire ? (6'h01 << sel) : 6'h00;
	end
endmodule // pmsc_link_model
`default_nettype wire

// file: pmsc_regs_tb.sv
// Purpose: Self-checking bench for the MAC-side register bank.
// Assumes: Master drives after rising edges; read data land one cycle later.
// Notes: Reserved control-register fields are written with their reset values; the first enable write and the status write set all bits.
`timescale 1ns/100ps
`default_nettype none
module pmsc_regs_tb
	import pmsc_pkg::*;
;
	logic        mclk = 1'b0, rst_n = 1'b0, swRst = 1'b0, regWr = 1'b0, regRd = 1'b0, fire = 1'b0;
	logic [4:0]  regAddr = 5'h00;
	logic [15:0] regWdata = 16'h0000, regRdata;
	logic [2:0]  sel = 3'h0, serAmplitude;
	logic [5:0]  evt;
	logic        fibNegComplete = 1'b0, pwrDownMain = 1'b0, pwrDownCopper = 1'b0, energyDetect = 1'b0;
	logic        upByBypass, upByNegotiation, serLinkDown, fifoErr, idleInserted, idleDeleted;
	logic        bypassEnable, fiberTxDisable, passOddPreamble, rxClkRun, irq;
	logic [15:0] bitOf [3] = '{16'h0080, 16'h0008, 16'h0004};
	int          nFail = 0, nChecks = 0;
	always #4 mclk = ~mclk;
	assign {idleDeleted, idleInserted, fifoErr, serLinkDown, upByNegotiation, upByBypass} = evt;
	pmsc_regs pmsc_regs_i (
		.mclk            (mclk),
		.rst_n           (rst_n),
		.swRst           (swRst),
		.regAddr         (regAddr),
		.regWdata        (regWdata),
		.regWr           (regWr),
		.regRd           (regRd),
		.regRdata        (regRdata),
		.upByBypass      (upByBypass),
		.upByNegotiation (upByNegotiation),
		.serLinkDown     (serLinkDown),
		.fibNegComplete  (fibNegComplete),
		.fifoErr         (fifoErr),
		.idleInserted    (idleInserted),
		.idleDeleted     (idleDeleted),
		.pwrDownMain     (pwrDownMain),
		.pwrDownCopper   (pwrDownCopper),
		.energyDetect    (energyDetect),
		.bypassEnable    (bypassEnable),
		.fiberTxDisable  (fiberTxDisable),
		.serAmplitude    (serAmplitude),
		.passOddPreamble (passOddPreamble),
		.rxClkRun        (rxClkRun),
		.irq             (irq)
	);
	pmsc_link_model pmsc_link_model_i (
		.mclk (mclk),
		.fire (fire),
		.sel  (sel),
		.evt  (evt)
	);
	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		nChecks++;
		if (got !== exp) begin
			nFail++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		@(posedge mclk);
		regAddr <= a;
		regWdata <= d;
		regWr <= 1'b1;
		@(posedge mclk);
		regWr <= 1'b0;
		@(negedge mclk);
	endtask
	task automatic rd(input logic [4:0] a, input logic [15:0] exp);
		@(posedge mclk);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge mclk);
		regRd <= 1'b0;
		@(negedge mclk);
		check("regRdata", exp, regRdata);
	endtask
	task automatic pulse(input logic [2:0] k);
		@(posedge mclk);
		sel <= k;
		fire <= 1'b1;
		@(posedge mclk);
		fire <= 1'b0;
		@(posedge mclk);
		@(negedge mclk);
	endtask
	task automatic softReset;
		@(posedge mclk);
		swRst <= 1'b1;
		@(posedge mclk);
		swRst <= 1'b0;
		@(negedge mclk);
	endtask
	task automatic giveVerdict;
		$display("checks %0d mismatches %0d", nChecks, nFail);
		if (nFail == 0 && nChecks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	// The whole run needs well under a thousand cycles.
	initial begin
		repeat (3000) @(posedge mclk);
		nFail++;
		giveVerdict;
	end
	initial begin
		repeat (10) @(posedge mclk);
		rst_n <= 1'b1;
		rd(OFS_SERCTL, SERCTL_RST);
		rd(OFS_MACCTL, MACCTL_RST);
		rd(OFS_INTEN, INTEN_RST);
		rd(OFS_STATUS, ZERO16);
		rd(5'h05, ZERO16);
		$display("reset values done");
		@(posedge mclk) fibNegComplete <= 1'b1;
		pulse(3'd0);
		rd(OFS_SERCTL, SERCTL_RST | 16'h0020);
		rd(OFS_FIBST, ZERO16);
		pulse(3'd2);
		pulse(3'd1);
		rd(OFS_SERCTL, SERCTL_RST);
		rd(OFS_FIBST, 16'h0800);
		$display("bypass outcome done");
		for (int i = 0; i < 8; i++) begin
			wr(OFS_SERCTL, 16'h0048 | 16'(i));
			check("serAmplitude", 16'(i), 16'(serAmplitude));
			check("fiberTxDisable", 16'h0001, 16'(fiberTxDisable));
			rd(OFS_SERCTL, 16'h0048 | 16'(i));
		end
		wr(OFS_SERCTL, 16'h0003);
		wr(OFS_MACCTL, 16'h4400);
		check("bypassEnable", 16'h0001, 16'(bypassEnable));
		check("passOddPreamble", 16'h0001, 16'(passOddPreamble));
		softReset;
		check("bypassEnable", 16'h0000, 16'(bypassEnable));
		check("passOddPreamble", 16'h0000, 16'(passOddPreamble));
		check("serAmplitude", 16'h0003, 16'(serAmplitude));
		pulse(3'd0);
		rd(OFS_SERCTL, 16'h0003);
		$display("control writes done");
		for (int i = 0; i < 3; i++) begin
			@(posedge mclk) {energyDetect, pwrDownCopper, pwrDownMain} <= 3'(1 << i);
			@(negedge mclk) check("rxClkRun", 16'h0000, 16'(rxClkRun));
		end
		wr(OFS_MACCTL, MACCTL_RST);
		wr(OFS_SERCTL, SERCTL_RST);
		check("rxClkRun", 16'h0000, 16'(rxClkRun));
		check("bypassEnable", 16'h0000, 16'(bypassEnable));
		softReset;
		check("rxClkRun", 16'h0001, 16'(rxClkRun));
		check("bypassEnable", 16'h0001, 16'(bypassEnable));
		check("passOddPreamble", 16'h0001, 16'(passOddPreamble));
		@(posedge mclk) {energyDetect, pwrDownCopper, pwrDownMain} <= 3'h0;
		$display("receive clock done");
		wr(OFS_INTEN, 16'hffff);
		rd(OFS_INTEN, EVENT_MASK);
		for (int i = 0; i < 3; i++) begin
			pulse(3'(i + 3));
			check("irq", 16'h0001, 16'(irq));
			rd(OFS_STATUS, bitOf[i]);
			check("irq", 16'h0000, 16'(irq));
			rd(OFS_STATUS, ZERO16);
		end
		softReset;
		rd(OFS_INTEN, EVENT_MASK);
		wr(OFS_INTEN, ZERO16);
		pulse(3'd3);
		check("irq", 16'h0000, 16'(irq));
		softReset;
		rd(OFS_STATUS, ZERO16);
		wr(OFS_STATUS, 16'hffff);
		rd(OFS_STATUS, ZERO16);
		$display("events done");
		giveVerdict;
	end
endmodule // pmsc_regs_tb
`default_nettype wire
